// ### core/pmc_pkg.sv
// package for the power-mode control block: modes, bit positions, reset values
`default_nettype none
package pmc_pkg;
  // control-write bit positions of the power control register image
  localparam int unsigned PMC_IDLE_BIT = 0;
  localparam int unsigned PMC_STOP_BIT = 1;
  localparam int unsigned PMC_CTRL_W = 8;
  // address the core fetches from after any reset
  localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
  // port match width
  localparam int unsigned PMC_PORT_W = 8;
  localparam logic [7:0] PMC_PORT_RST = 8'h00;
  // power modes, one-hot
  typedef enum logic [3:0] {
    PMC_NORMAL = 4'h1,
    PMC_IDLE = 4'h2,
    PMC_STOP = 4'h4,
    PMC_SHUTDOWN = 4'h8
  } pmc_mode_t;
endpackage : pmc_pkg
`default_nettype wire

// ### core/pmc_power_mode_control.sv
// power-mode control: normal, idle, stop and shutdown sequencing for the core
// Function
// - idle select bit halts the processor after the writing instruction completes
// - idle keeps every register and memory content unchanged
// - idle leaves analog and digital peripherals running
// - idle ends on any enabled interrupt or any reset
// - interrupt ending idle clears idle bit, restarts processor, services interrupt
// - after handler returns, execution continues after the idle-entering instruction
// - reset ending idle runs normal reset sequence, fetch from address zero
// - stop bit with regulator-off bit clear enters stop after the write
// - stop halts oscillator, processor and all digital peripherals
// - stop ends only by internal or external reset, never interrupts
// - stop bit with regulator-off bit set enters stop then powers regulator down; the code goes straight to shutdown
// - shutdown removes power from core, memories and peripherals
// - shutdown ends only by external pin reset or power-on reset
// - port-match change can wake from idle or raise an interrupt
`default_nettype none
module pmc_power_mode_control
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // processor core side
  input wire logic ctrl_wr_i,
  input wire logic [pmc_pkg::PMC_CTRL_W-1:0] ctrl_wdata_i,
  input wire logic instr_done_i,
  input wire logic regulator_off_in_stop_i,
  // interrupt system and reset sources
  input wire logic irq_enabled_pending_i,
  input wire logic int_reset_i,
  input wire logic pin_reset_i,
  input wire logic por_reset_i,
  // port match
  input wire logic [pmc_pkg::PMC_PORT_W-1:0] port_pins_i,
  input wire logic [pmc_pkg::PMC_PORT_W-1:0] port_match_val_i,
  input wire logic [pmc_pkg::PMC_PORT_W-1:0] port_mask_i,
  // control outputs
  output logic cpu_halt_o,
  output logic cpu_reset_o,
  output logic [15:0] fetch_addr_o,
  output logic osc_en_o,
  output logic dig_periph_en_o,
  output logic regulator_en_o,
  output logic core_power_en_o,
  output logic port_match_irq_o,
  output logic idle_sel_o,
  output logic stop_sel_o,
  output logic [3:0] mode_o
);
  import pmc_pkg::*;

  // two-flop sync of the asynchronous pins; first stage read only by second
  logic [PMC_PORT_W-1:0] pin_s1_ff, pin_s2_ff;
  logic rstpin_s1_ff, rstpin_s2_ff, por_s1_ff, por_s2_ff;
  always_ff @(posedge ref_clk_i)
  begin
    pin_s1_ff <= port_pins_i;
    pin_s2_ff <= pin_s1_ff;
    rstpin_s1_ff <= pin_reset_i;
    rstpin_s2_ff <= rstpin_s1_ff;
    por_s1_ff <= por_reset_i;
    por_s2_ff <= por_s1_ff;
  end

  // wake sources; in shutdown only the pin and power-on resets are heard
  logic hard_rst, any_rst, port_match;
  assign hard_rst = srst_i | rstpin_s2_ff | por_s2_ff;
  assign any_rst = hard_rst | int_reset_i;
  assign port_match = |((pin_s2_ff ^ port_match_val_i) & port_mask_i);

  // mode state and select bits
  pmc_mode_t mode_ff, nxt_mode;
  logic idle_sel_ff, nxt_idle_sel, stop_sel_ff, nxt_stop_sel;
  logic pend_idle_ff, nxt_pend_idle, pend_stop_ff, nxt_pend_stop;
  logic cpu_rst_ff, nxt_cpu_rst, pm_irq_ff, nxt_pm_irq;

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_idle_sel = idle_sel_ff;
    nxt_stop_sel = stop_sel_ff;
    nxt_pend_idle = pend_idle_ff;
    nxt_pend_stop = pend_stop_ff;
    nxt_cpu_rst = 1'b0;
    nxt_pm_irq = port_match;
    case (mode_ff)
      PMC_NORMAL:
      begin
        if (ctrl_wr_i)
        begin
          // latch the write; the mode changes once the instruction retires
          nxt_idle_sel = ctrl_wdata_i[PMC_IDLE_BIT];
          nxt_stop_sel = ctrl_wdata_i[PMC_STOP_BIT];
          nxt_pend_idle = ctrl_wdata_i[PMC_IDLE_BIT];
          nxt_pend_stop = ctrl_wdata_i[PMC_STOP_BIT];
        end
        if (instr_done_i && (pend_stop_ff || pend_idle_ff))
        begin
          nxt_pend_idle = 1'b0;
          nxt_pend_stop = 1'b0;
          // stop outranks idle when both bits are written together
          if (pend_stop_ff)
            nxt_mode = regulator_off_in_stop_i ? PMC_SHUTDOWN : PMC_STOP;
          else
            nxt_mode = PMC_IDLE;
        end
      end
      PMC_IDLE:
      begin
        // registers untouched here, only the halt changes
        if (irq_enabled_pending_i || port_match)
        begin
          nxt_idle_sel = 1'b0;
          nxt_mode = PMC_NORMAL;
        end
      end
      PMC_STOP: nxt_mode = PMC_STOP;
      PMC_SHUTDOWN: nxt_mode = PMC_SHUTDOWN;
      default: nxt_mode = PMC_NORMAL;
    endcase
    // internal reset cannot reach a powered-down core
    if (hard_rst || (int_reset_i && mode_ff != PMC_SHUTDOWN))
    begin
      nxt_mode = PMC_NORMAL;
      nxt_idle_sel = 1'b0;
      nxt_stop_sel = 1'b0;
      nxt_pend_idle = 1'b0;
      nxt_pend_stop = 1'b0;
      nxt_cpu_rst = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      mode_ff <= PMC_NORMAL;
      idle_sel_ff <= 1'b0;
      stop_sel_ff <= 1'b0;
      pend_idle_ff <= 1'b0;
      pend_stop_ff <= 1'b0;
      cpu_rst_ff <= 1'b1;
      pm_irq_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      idle_sel_ff <= nxt_idle_sel;
      stop_sel_ff <= nxt_stop_sel;
      pend_idle_ff <= nxt_pend_idle;
      pend_stop_ff <= nxt_pend_stop;
      cpu_rst_ff <= nxt_cpu_rst;
      pm_irq_ff <= nxt_pm_irq;
    end
  end

  // registered decode of the mode onto the power and clock gates
  logic halt_ff, osc_ff, dig_ff, reg_ff, pwr_ff;
  logic nxt_halt, nxt_osc, nxt_dig, nxt_reg, nxt_pwr;
  // fetch address kept in a flop so every output leaves from a register
  logic [15:0] fetch_ff, nxt_fetch;
  always_comb
  begin
    nxt_halt = (nxt_mode != PMC_NORMAL);
    nxt_osc = (nxt_mode == PMC_NORMAL) || (nxt_mode == PMC_IDLE);
    nxt_dig = nxt_osc;
    nxt_reg = (nxt_mode != PMC_SHUTDOWN);
    nxt_pwr = (nxt_mode != PMC_SHUTDOWN);
    nxt_fetch = PMC_RESET_VECTOR;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      halt_ff <= 1'b0;
      osc_ff <= 1'b1;
      dig_ff <= 1'b1;
      reg_ff <= 1'b1;
      pwr_ff <= 1'b1;
      fetch_ff <= PMC_RESET_VECTOR;
    end
    else
    begin
      halt_ff <= nxt_halt;
      osc_ff <= nxt_osc;
      dig_ff <= nxt_dig;
      reg_ff <= nxt_reg;
      pwr_ff <= nxt_pwr;
      fetch_ff <= nxt_fetch;
    end
  end

  assign cpu_halt_o = halt_ff;
  assign cpu_reset_o = cpu_rst_ff;
  assign fetch_addr_o = fetch_ff;
  assign osc_en_o = osc_ff;
  assign dig_periph_en_o = dig_ff;
  assign regulator_en_o = reg_ff;
  assign core_power_en_o = pwr_ff;
  assign port_match_irq_o = pm_irq_ff;
  assign idle_sel_o = idle_sel_ff;
  assign stop_sel_o = stop_sel_ff;
  assign mode_o = mode_ff;

  // checks
  idle_wake_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_IDLE && irq_enabled_pending_i && !any_rst)
      |=> (mode_ff == PMC_NORMAL && !idle_sel_ff && !cpu_halt_o))
    else $error("idle not left on interrupt");
  stop_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_STOP && !any_rst) |=> mode_ff == PMC_STOP)
    else $error("stop left without reset");
  shut_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_SHUTDOWN && !rstpin_s2_ff && !por_s2_ff)
      |=> mode_ff == PMC_SHUTDOWN)
    else $error("shutdown left without pin or power-on reset");
  idle_enter_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_NORMAL && pend_idle_ff && !pend_stop_ff && instr_done_i && !any_rst)
      |=> mode_ff == PMC_IDLE ##0 cpu_halt_o)
    else $error("idle not entered");
  stop_enter_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_NORMAL && pend_stop_ff && instr_done_i && !regulator_off_in_stop_i
      && !any_rst) |=> (mode_ff == PMC_STOP && !osc_en_o && !dig_periph_en_o))
    else $error("stop not entered");
  shut_enter_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode_ff == PMC_NORMAL && pend_stop_ff && instr_done_i && regulator_off_in_stop_i
      && !any_rst) |=> (!regulator_en_o && !core_power_en_o))
    else $error("shutdown not entered");
  reset_clear_a: assert property (@(posedge ref_clk_i)
    (rstpin_s2_ff || por_s2_ff) |=> (!idle_sel_o && !stop_sel_o && cpu_reset_o
      && mode_ff == PMC_NORMAL))
    else $error("reset did not restore normal mode");
  idle_periph_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    mode_ff == PMC_IDLE |-> (osc_en_o && dig_periph_en_o))
    else $error("peripherals stopped in idle");
  match_irq_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    port_match |=> port_match_irq_o)
    else $error("port match lost");
endmodule : pmc_power_mode_control
`default_nettype wire

// ### dv/pmc_core_model.sv
// core-side model: a power control write followed by its completion pulse
`default_nettype none
module pmc_core_model
  import pmc_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // request from the bench
  input wire logic go_i,
  input wire logic [pmc_pkg::PMC_CTRL_W-1:0] data_i,
  // core outputs
  output logic ctrl_wr_o,
  output logic [pmc_pkg::PMC_CTRL_W-1:0] ctrl_wdata_o,
  output logic instr_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ctrl_wr_o = 1'b0;
    ctrl_wdata_o = 8'h00;
    instr_done_o = 1'b0;
  end
  // analog parts are left to software, the model never asks the block to stop them
  always @(negedge ref_clk_i)
  begin
    ctrl_wr_o <= go_i;
    // done trails the write by one cycle, never with it
    instr_done_o <= ctrl_wr_o;
    // released data bus toggles so a stale value cannot pass
    ctrl_wdata_o <= go_i ? data_i : ~ctrl_wdata_o;
  end
endmodule : pmc_core_model
`default_nettype wire

// ### dv/power_mode_control_tb.sv
// testbench for the power-mode control block
`default_nettype none
module power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, regoff = 1'b0, irq = 1'b0;
  logic irst = 1'b0, prst = 1'b0, por = 1'b0, saw_rst = 1'b0;
  logic [7:0] data = 8'h00, pins = 8'h00, mask = 8'hff, mval = 8'h00, wdata;
  logic wr, done, halt, cpu_rst, osc, dig, reg_en, core_en, pm_irq, idle_sel, stop_sel;
  logic [15:0] fetch;
  logic [3:0] mode;
  int fails = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  pmc_core_model u_pmc_core_model (.ref_clk_i(clk), .go_i(go), .data_i(data),
    .ctrl_wr_o(wr), .ctrl_wdata_o(wdata), .instr_done_o(done));
  pmc_power_mode_control u_pmc_power_mode_control (.ref_clk_i(clk), .srst_i(srst),
    .ctrl_wr_i(wr), .ctrl_wdata_i(wdata), .instr_done_i(done),
    .regulator_off_in_stop_i(regoff), .irq_enabled_pending_i(irq), .int_reset_i(irst),
    .pin_reset_i(prst), .por_reset_i(por), .port_pins_i(pins),
    .port_match_val_i(mval), .port_mask_i(mask), .cpu_halt_o(halt),
    .cpu_reset_o(cpu_rst), .fetch_addr_o(fetch), .osc_en_o(osc),
    .dig_periph_en_o(dig), .regulator_en_o(reg_en), .core_power_en_o(core_en),
    .port_match_irq_o(pm_irq), .idle_sel_o(idle_sel), .stop_sel_o(stop_sel),
    .mode_o(mode));
  task automatic finish_test();
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  // bounded wait for a mode, noting any core reset pulse on the way
  task automatic wait_mode(input logic [3:0] exp);
    int n;
    n = 0;
    saw_rst = cpu_rst;
    while (mode !== exp && n < 20)
    begin
      @(negedge clk);
      saw_rst |= cpu_rst;
      n++;
    end
    chk(mode, exp);
    if (mode !== exp)
      finish_test();
  endtask : wait_mode
  task automatic request(input logic [7:0] d, input logic ro);
    regoff <= ro;
    data <= d;
    go <= 1'b1;
    cycles(1);
    go <= 1'b0;
  endtask : request
  task automatic do_reset();
    srst <= 1'b1;
    cycles(12);
    srst <= 1'b0;
    cycles(1);
    chk({mode, cpu_rst, halt, idle_sel, stop_sel, osc, dig, reg_en, core_en},
      {PMC_NORMAL, 8'h0f});
  endtask : do_reset
  // idle entry, a refused write, then an exact one-cycle interrupt wake
  task automatic t_idle_irq();
    request(8'h01, 1'b0);
    wait_mode(PMC_IDLE);
    chk({halt, osc, dig, idle_sel}, 4'hf);
    request(8'h02, 1'b0);
    cycles(4);
    chk({mode, idle_sel, stop_sel}, {PMC_IDLE, 2'b10});
    irq <= 1'b1;
    cycles(1);
    chk({mode, halt, idle_sel, cpu_rst}, {PMC_NORMAL, 3'b000});
    irq <= 1'b0;
  endtask : t_idle_irq
  task automatic t_idle_reset();
    request(8'h01, 1'b0);
    wait_mode(PMC_IDLE);
    irst <= 1'b1;
    cycles(1);
    irst <= 1'b0;
    wait_mode(PMC_NORMAL);
    chk({idle_sel, saw_rst, fetch}, {2'b01, PMC_RESET_VECTOR});
  endtask : t_idle_reset
  // stop ignores interrupts, leaves on internal reset; stop beats idle when both set
  task automatic t_stop(input logic [7:0] d);
    request(d, 1'b0);
    wait_mode(PMC_STOP);
    chk({osc, dig, halt, reg_en, stop_sel}, 5'b00111);
    irq <= 1'b1;
    cycles(8);
    chk(mode, PMC_STOP);
    irq <= 1'b0;
    irst <= 1'b1;
    cycles(1);
    irst <= 1'b0;
    wait_mode(PMC_NORMAL);
    chk({saw_rst, stop_sel, idle_sel}, 3'b100);
  endtask : t_stop
  task automatic t_shutdown(input logic use_por);
    request(8'h02, 1'b1);
    wait_mode(PMC_SHUTDOWN);
    chk({reg_en, core_en, osc, dig}, 4'h0);
    irst <= 1'b1;
    cycles(8);
    chk(mode, PMC_SHUTDOWN);
    irst <= 1'b0;
    por <= use_por;
    prst <= ~use_por;
    cycles(1);
    por <= 1'b0;
    prst <= 1'b0;
    wait_mode(PMC_NORMAL);
    chk(saw_rst, 1'b1);
  endtask : t_shutdown
  // a masked-off pin change must not wake, an unmasked one must
  task automatic t_port_match();
    mask <= 8'hef;
    pins <= 8'h10;
    request(8'h01, 1'b0);
    wait_mode(PMC_IDLE);
    cycles(4);
    chk({mode, pm_irq}, {PMC_IDLE, 1'b0});
    // pins equal to the match value must not wake either
    mask <= 8'hff;
    mval <= 8'h10;
    cycles(4);
    chk({mode, pm_irq}, {PMC_IDLE, 1'b0});
    mval <= 8'h00;
    wait_mode(PMC_NORMAL);
    chk(pm_irq, 1'b1);
    pins <= 8'h00;
  endtask : t_port_match
  // reset in mid-run while idle brings the block back to normal
  task automatic t_reset_in_idle();
    request(8'h01, 1'b0);
    wait_mode(PMC_IDLE);
    do_reset();
  endtask : t_reset_in_idle
  initial
  begin
    do_reset();
    t_idle_irq();
    t_idle_reset();
    t_stop(8'h02);
    t_stop(8'h03);
    t_shutdown(1'b0);
    t_shutdown(1'b1);
    t_port_match();
    t_reset_in_idle();
    finish_test();
  end
endmodule : power_mode_control_tb
`default_nettype wire
